// ===== core/wdbus_map.svh
`ifndef WDBUS_MAP_SVH
`define WDBUS_MAP_SVH

// Register offsets (7-bit register address)
`define HWC_ADDR 7'h02
`define WDC_ADDR 7'h03
`define BUSC_ADDR 7'h04

// Writable bit masks; all other positions are reserved
`define HWC_WMASK 16'h1e64
`define WDC_WMASK 16'h8077
`define BUSC_WMASK 16'h00ff

// Reset values
`define HWC_POR_VAL 16'h0000
`define WDC_RST_VAL 16'h0014
`define BUSC_RST_VAL 16'h0000

// Bits kept across soft reset, restart and fail-safe entry, and bits fail-safe entry sets
`define HWC_SOFT_KEEP 16'h0200
`define HWC_RESTART_KEEP 16'h1240
`define WDC_RESTART_KEEP 16'h0010
`define BUSC_RESTART_KEEP 16'h00d4
`define BUSC_FAILSAFE_KEEP 16'h00e0
`define BUSC_FAILSAFE_SET 16'h0009

// Field positions
`define HWC_FAIL_SW_BIT 5
`define HWC_STOP_WD_B_BIT 2
`define WDC_CHECKSUM_BIT 15
`define WDC_STOP_WD_A_BIT 6
`define WDC_TYPE_BIT 5
`define WDC_BUS_WAKE_BIT 4
`define BUSC_LIN_FLASH_BIT 7
`define BUSC_LIN_LOW_SLOPE_BIT 6
`define BUSC_LIN_TXTO_BIT 5

// Watchdog period figures in ms
`define WD_PERIOD_0_MS 14'h000a
`define WD_PERIOD_1_MS 14'h0014
`define WD_PERIOD_2_MS 14'h0032
`define WD_PERIOD_3_MS 14'h0064
`define WD_PERIOD_4_MS 14'h00c8
`define WD_PERIOD_5_MS 14'h01f4
`define WD_PERIOD_7_MS 14'h2710

`endif

// ===== core/wdbus_pkg.sv
package wdbus_pkg;

    typedef struct packed {
        logic [15:0] hw;
        logic [15:0] wd;
        logic [15:0] bus;
        logic [15:0] rd_data;
        logic rd_valid;
        logic fail_out;
        logic wake_start;
        logic [13:0] period_ms;
        logic sel_wake;
    } regs_state_t;

endpackage

// ===== core/watchdog_bus_mode_control_regs.sv
`timescale 1ns/1ns
`include "wdbus_map.svh"
// Summary of operation
// - POR clears control register; soft reset keeps bit9.
// - Restart keeps control bits 12, 9, 6.
// - Recorded failure holds fail outputs despite software clear.
// - Restart clears software fail activation; outputs follow failure.
// - Stop to Normal clears stop watchdog bit b.
// - Checksum bit 15 writable, host keeps checksum right.
// - Watchdog bit6 deactivates watchdog in Stop Mode.
// - Watchdog bit5 selects time-out or window.
// - Bit4 lets bus wake start watchdog.
// - Period field selects documented watchdog periods.
// - Watchdog register resets 0x0014; restart reloads 0x0014, so bit4 ends set.
// - LIN bit7 turns off slope control.
// - LIN bit6 selects low slope mode.
// - Bit5 enables LIN transmit time-out supervision.
// - LIN mode field bits 4:3 encoding.
// - CAN mode field; top bit adds selective wake.
// - Reserved bits ignore writes, read zero.
// - Sleep entry without system error moves CAN normal to wake capable.
// - Fail-safe entry forces CAN, LIN wake capable.
module watchdog_bus_mode_control_regs
    import wdbus_pkg::*;
#(
    parameter int ADDR_W = 7,
    parameter int DATA_W = 16,
    parameter logic [13:0] PERIOD_6_MS = 14'h03e8
) (
    input wire logic i_clk, // 250 MHz clock
    input wire logic i_srst, // Power-on reset, sync, high
    input wire logic i_ce, // Clock enable, freezes state when low
    input wire logic i_soft_reset, // Soft reset pulse
    input wire logic i_restart_entry, // Restart Mode entry pulse
    input wire logic i_stop_to_normal, // Stop to Normal change pulse
    input wire logic i_sleep_entry, // Sleep Mode entry pulse
    input wire logic i_failsafe_entry, // Fail-Safe entry on failure, pulse
    input wire logic i_system_error_flag, // System error flag level
    input wire logic i_failure_flag, // Recorded failure driving fail outputs
    input wire logic i_bus_wake_in_stop, // CAN or LIN wake in Stop Mode, pulse
    input wire logic i_wr_en, // Register write strobe
    input wire logic i_rd_en, // Register read strobe
    input wire logic [ADDR_W-1:0] i_addr, // Register address
    input wire logic [DATA_W-1:0] i_wr_data, // Write data
    output logic [DATA_W-1:0] o_rd_data, // Read data
    output logic o_rd_valid, // Read data valid pulse
    output logic o_fail_output_pins, // Fail outputs active
    output logic [DATA_W-1:0] o_hardware_control_reg, // Hardware control contents
    output logic [DATA_W-1:0] o_watchdog_control_reg, // Watchdog control contents
    output logic [DATA_W-1:0] o_bus_transceiver_control, // Bus control contents
    output logic o_watchdog_stop_off, // Watchdog off in Stop Mode
    output logic o_watchdog_window_mode, // 1 window, 0 time-out
    output logic [13:0] o_watchdog_period_ms, // Watchdog period in ms
    output logic o_watchdog_bus_wake_start, // Start watchdog, long window, pulse
    output logic o_lin_slope_off, // LIN slope control off
    output logic o_lin_low_slope_select, // LIN low slope mode
    output logic o_lin_transmit_timeout_enable, // LIN transmit time-out enabled
    output logic [1:0] o_lin_mode, // 00 off 01 wake 10 rx 11 normal
    output logic [1:0] o_can_mode, // 00 off 01 wake 10 rx 11 normal
    output logic o_selective_wake // CAN selective wake active
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (DATA_W != 16 || ADDR_W < 3) begin : g_bad_param
        $error("watchdog_bus_mode_control_regs: unsupported width");
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [13:0] period_of(input logic [2:0] code);
        logic [13:0] ms;
        case (code)
            3'h0: ms = `WD_PERIOD_0_MS;
            3'h1: ms = `WD_PERIOD_1_MS;
            3'h2: ms = `WD_PERIOD_2_MS;
            3'h3: ms = `WD_PERIOD_3_MS;
            3'h4: ms = `WD_PERIOD_4_MS;
            3'h5: ms = `WD_PERIOD_5_MS;
            3'h6: ms = PERIOD_6_MS;
            default: ms = `WD_PERIOD_7_MS;
        endcase
        return ms;
    endfunction

    function automatic logic [15:0] merge(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [15:0] wmask);
        return (old_v & ~wmask) | (new_v & wmask);
    endfunction

    regs_state_t st;
    regs_state_t next_st;
    logic [2:0] reg_sel;

    assign reg_sel = {i_addr == ADDR_W'(`BUSC_ADDR),
                      i_addr == ADDR_W'(`WDC_ADDR),
                      i_addr == ADDR_W'(`HWC_ADDR)};

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.rd_valid = 1'b0;
        next_st.wake_start = 1'b0;
        // Register writes; reserved bits never take data
        if (i_wr_en) begin
            if (reg_sel[0]) begin
                next_st.hw = merge(st.hw, i_wr_data, `HWC_WMASK);
            end
            if (reg_sel[1]) begin
                next_st.wd = merge(st.wd, i_wr_data, `WDC_WMASK);
            end
            if (reg_sel[2]) begin
                next_st.bus = merge(st.bus, i_wr_data, `BUSC_WMASK);
            end
        end
        // Register reads show the stored state
        if (i_rd_en) begin
            next_st.rd_valid = 1'b1;
            case (reg_sel)
                3'b001: next_st.rd_data = st.hw;
                3'b010: next_st.rd_data = st.wd;
                3'b100: next_st.rd_data = st.bus;
                default: next_st.rd_data = 16'h0000;
            endcase
        end
        // Device updates win over a write in the same cycle
        if (i_stop_to_normal) begin
            next_st.hw[`HWC_STOP_WD_B_BIT] = 1'b0;
        end
        if (i_sleep_entry && !i_system_error_flag && next_st.bus[1:0] != 2'b00) begin
            next_st.bus[1:0] = 2'b01;
        end
        if (i_failsafe_entry) begin
            next_st.bus = (next_st.bus & `BUSC_FAILSAFE_KEEP) | `BUSC_FAILSAFE_SET;
        end
        if (i_bus_wake_in_stop && st.wd[`WDC_BUS_WAKE_BIT]) begin
            next_st.wake_start = 1'b1;
        end
        if (i_soft_reset) begin
            next_st.hw = st.hw & `HWC_SOFT_KEEP;
            next_st.wd = `WDC_RST_VAL;
            next_st.bus = `BUSC_RST_VAL;
            next_st.wake_start = 1'b0;
        end else if (i_restart_entry) begin
            next_st.hw = st.hw & `HWC_RESTART_KEEP;
            next_st.wd = `WDC_RST_VAL | (st.wd & `WDC_RESTART_KEEP);
            next_st.bus = st.bus & `BUSC_RESTART_KEEP;
            next_st.wake_start = 1'b0;
        end
        // Failure keeps outputs on whatever software does
        next_st.fail_out = i_failure_flag | next_st.hw[`HWC_FAIL_SW_BIT];
        next_st.period_ms = period_of(next_st.wd[2:0]);
        next_st.sel_wake = next_st.bus[2] && (next_st.bus[1:0] != 2'b00);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            st.hw <= `HWC_POR_VAL;
            st.wd <= `WDC_RST_VAL;
            st.bus <= `BUSC_RST_VAL;
            st.rd_data <= 16'h0000;
            st.rd_valid <= 1'b0;
            st.fail_out <= 1'b0;
            st.wake_start <= 1'b0;
            st.period_ms <= `WD_PERIOD_4_MS;
            st.sel_wake <= 1'b0;
        end else if (i_ce) begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_rd_data = st.rd_data;
    assign o_rd_valid = st.rd_valid;
    assign o_fail_output_pins = st.fail_out;
    assign o_hardware_control_reg = st.hw;
    assign o_watchdog_control_reg = st.wd;
    assign o_bus_transceiver_control = st.bus;
    assign o_watchdog_stop_off = st.wd[`WDC_STOP_WD_A_BIT];
    assign o_watchdog_window_mode = st.wd[`WDC_TYPE_BIT];
    assign o_watchdog_period_ms = st.period_ms;
    assign o_watchdog_bus_wake_start = st.wake_start;
    assign o_lin_slope_off = st.bus[`BUSC_LIN_FLASH_BIT];
    assign o_lin_low_slope_select = st.bus[`BUSC_LIN_LOW_SLOPE_BIT];
    assign o_lin_transmit_timeout_enable = st.bus[`BUSC_LIN_TXTO_BIT];
    assign o_lin_mode = st.bus[4:3];
    assign o_can_mode = st.bus[1:0];
    assign o_selective_wake = st.sel_wake;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);

    logic calm;
    assign calm = !i_soft_reset && !i_restart_entry;

    sequence s_soft;
        i_ce && i_soft_reset;
    endsequence

    sequence s_restart;
        i_ce && !i_soft_reset && i_restart_entry;
    endsequence

    sequence s_sleep_normal;
        i_ce && calm && !i_failsafe_entry && i_sleep_entry
            && !i_system_error_flag && !(i_wr_en && reg_sel[2])
            && st.bus[1:0] == 2'b11;
    endsequence

    sequence s_wr_hw;
        i_ce && calm && !i_stop_to_normal && i_wr_en && reg_sel == 3'b001;
    endsequence

    sequence s_wr_wd;
        i_ce && calm && i_wr_en && reg_sel == 3'b010;
    endsequence

    sequence s_bus_wake;
        i_ce && calm && i_bus_wake_in_stop && st.wd[`WDC_BUS_WAKE_BIT];
    endsequence

    a_por_hw_zero: assert property (disable iff (1'b0)
        i_srst |=> st.hw == 16'h0000 && st.wd == 16'h0014)
        else $error("power-on reset values wrong");

    a_soft_keep_bit: assert property (
        s_soft |=> st.hw == ($past(st.hw) & 16'h0200) && st.wd == 16'h0014)
        else $error("soft reset values wrong");

    a_restart_hw_keep: assert property (
        s_restart |=> st.hw == ($past(st.hw) & 16'h1240) && !st.hw[5])
        else $error("restart hardware control wrong");

    a_restart_wd_keep: assert property (
        s_restart |=> st.wd == (16'h0014 | ($past(st.wd) & 16'h0010)))
        else $error("restart watchdog control wrong");

    a_fail_out_held: assert property (
        i_ce && i_failure_flag |=> o_fail_output_pins)
        else $error("fail outputs released during failure");

    a_fail_out_off: assert property (
        s_restart ##0 !i_failure_flag |=> !o_fail_output_pins)
        else $error("fail outputs stay on after restart");

    a_stop_clear_b: assert property (
        i_ce && calm && i_stop_to_normal |=> !st.hw[2])
        else $error("stop watchdog bit b not cleared");

    a_reserved_zero: assert property (
        (st.hw & ~16'h1e64) == 16'h0000 && (st.wd & ~16'h8077) == 16'h0000
            && st.bus[15:8] == 8'h00)
        else $error("reserved bits not zero");

    a_sleep_can_wake: assert property (
        s_sleep_normal |=> st.bus[1:0] == 2'b01 && st.bus[2] == $past(st.bus[2]))
        else $error("sleep entry did not move CAN to wake");

    a_failsafe_bus: assert property (
        i_ce && calm && i_failsafe_entry |=> st.bus[4:0] == 5'h09)
        else $error("fail-safe bus control wrong");

    a_bus_wake_start: assert property (
        s_bus_wake |=> o_watchdog_bus_wake_start)
        else $error("bus wake did not start watchdog");

    a_wake_one_cycle: assert property (
        i_ce && !(i_bus_wake_in_stop && st.wd[4]) |=> !o_watchdog_bus_wake_start)
        else $error("watchdog start pulse too long");

    a_read_wd_back: assert property (
        i_ce && i_rd_en && reg_sel == 3'b010 |=> o_rd_valid && o_rd_data == $past(st.wd))
        else $error("watchdog control read back wrong");

    a_period_table: assert property (
        i_ce ##1 st.wd[2:0] == 3'h5 |-> o_watchdog_period_ms == 14'h01f4)
        else $error("watchdog period decode wrong");

    a_period_long: assert property (
        i_ce ##1 st.wd[2:0] == 3'h7 |-> o_watchdog_period_ms == 14'h2710)
        else $error("longest watchdog period wrong");

    a_write_hw_lands: assert property (
        s_wr_hw |=> st.hw == ($past(i_wr_data) & 16'h1e64))
        else $error("hardware control write lost");

    a_fail_out_sw: assert property (
        s_wr_hw ##0 i_wr_data[5] |=> o_fail_output_pins)
        else $error("software did not turn fail outputs on");

    a_write_wd_lands: assert property (
        s_wr_wd |=> st.wd == ($past(i_wr_data) & 16'h8077))
        else $error("watchdog control write lost");

    a_write_bus_lands: assert property (
        i_ce && calm && !i_sleep_entry && !i_failsafe_entry && i_wr_en && reg_sel == 3'b100
            |=> st.bus == ($past(i_wr_data) & 16'h00ff))
        else $error("bus control write lost");

    a_hw_read_back: assert property (
        i_ce && i_rd_en && reg_sel == 3'b001 |=> o_rd_valid && o_rd_data == $past(st.hw))
        else $error("hardware control read back wrong");

    a_unmapped_read: assert property (
        i_ce && i_rd_en && reg_sel == 3'b000 |=> o_rd_valid && o_rd_data == 16'h0000)
        else $error("unmapped read not zero");

    a_sel_wake_out: assert property (
        o_selective_wake == (st.bus[2] && st.bus[1:0] != 2'b00))
        else $error("selective wake output wrong");

    a_failsafe_keep: assert property (
        i_ce && calm && i_failsafe_entry && !(i_wr_en && reg_sel[2])
            |=> st.bus[15:5] == $past(st.bus[15:5]))
        else $error("fail-safe entry changed kept bits");

    a_sleep_error_keep: assert property (
        i_ce && calm && !i_failsafe_entry && i_sleep_entry && i_system_error_flag
            && !(i_wr_en && reg_sel[2]) |=> st.bus == $past(st.bus))
        else $error("sleep entry changed bus with system error");

    a_soft_bus_clear: assert property (
        s_soft |=> st.bus == 16'h0000 && !o_watchdog_bus_wake_start)
        else $error("soft reset bus control wrong");

    a_restart_bus_keep: assert property (
        s_restart |=> st.bus == ($past(st.bus) & 16'h00d4) && !o_watchdog_bus_wake_start)
        else $error("restart bus control wrong");

    a_ce_freeze: assert property (
        !i_ce |=> $stable(st))
        else $error("state moved while clock enable low");

endmodule // watchdog_bus_mode_control_regs

// ===== tb/spi_host_model.sv
`timescale 1ns/1ns
// ------
// Host side of the decoded register word port
// ------
module spi_host_model (
    input wire logic i_clk, // Clock
    input wire logic [15:0] i_rd_data, // Read answer
    input wire logic i_rd_valid, // Read answer strobe
    output logic o_wr_en, // Write strobe
    output logic o_rd_en, // Read strobe
    output logic [6:0] o_addr, // Word address
    output logic [15:0] o_wr_data // Write word
);
    initial begin
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_addr = 7'h00;
        o_wr_data = 16'h0000;
    end

    // One access: held over one taking edge, answer taken at the next falling edge
    task automatic acc(input bit w, input logic [6:0] a, input logic [15:0] d,
                       output logic [15:0] q, output logic v);
        @(negedge i_clk);
        o_wr_en = w;
        o_rd_en = !w;
        o_addr = a;
        o_wr_data = d;
        @(negedge i_clk);
        q = i_rd_data;
        v = i_rd_valid;
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        // Released lines show the inverse so stale values cannot pass
        o_addr = ~a;
        o_wr_data = ~d;
    endtask
endmodule // spi_host_model

// ===== tb/watchdog_bus_mode_control_regs_bench.sv
`timescale 1ns/1ns
`include "wdbus_map.svh"
module watchdog_bus_mode_control_regs_bench;
    logic i_clk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic sys_err = 1'b0;
    logic fail = 1'b0;
    logic [5:0] ev = 6'h00;
    logic wr_en, rd_en, rd_valid, fail_pins, ws, so, win, lso, lls, lto, sw, v;
    logic [6:0] addr;
    logic [15:0] wr_data, rd_data, hw, wd, bus, q;
    logic [13:0] per;
    logic [1:0] lm, cm;
    int n_errors = 0;
    int checks = 0;
    int seed = 57861;
    int mh, mw, mb, k, a;
    int per_tab[8] = '{10, 20, 50, 100, 200, 500, 1000, 10000};

    always #2 i_clk = ~i_clk;

    watchdog_bus_mode_control_regs dut (
        .i_clk(i_clk), .i_srst(srst), .i_ce(ce), .i_soft_reset(ev[0]),
        .i_restart_entry(ev[1]), .i_stop_to_normal(ev[2]), .i_sleep_entry(ev[3]),
        .i_failsafe_entry(ev[4]), .i_system_error_flag(sys_err), .i_failure_flag(fail),
        .i_bus_wake_in_stop(ev[5]), .i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr),
        .i_wr_data(wr_data), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
        .o_fail_output_pins(fail_pins), .o_hardware_control_reg(hw),
        .o_watchdog_control_reg(wd),
        .o_bus_transceiver_control(bus), .o_watchdog_stop_off(so),
        .o_watchdog_window_mode(win), .o_watchdog_period_ms(per),
        .o_watchdog_bus_wake_start(ws), .o_lin_slope_off(lso),
        .o_lin_low_slope_select(lls), .o_lin_transmit_timeout_enable(lto),
        .o_lin_mode(lm), .o_can_mode(cm), .o_selective_wake(sw));

    spi_host_model host (
        .i_clk(i_clk), .i_rd_data(rd_data), .i_rd_valid(rd_valid), .o_wr_en(wr_en),
        .o_rd_en(rd_en), .o_addr(addr), .o_wr_data(wr_data));

    task automatic give_verdict;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cmp_all;
        @(negedge i_clk);
        chk(hw, 16'(mh));
        chk(wd, 16'(mw));
        chk(bus, 16'(mb));
        chk(16'(fail_pins), 16'(fail | mh[5]));
        chk(16'(rd_valid), 16'h0000);
        chk(16'(so), 16'(mw[6]));
        chk(16'(win), 16'(mw[5]));
        chk(16'(per), 16'(per_tab[mw[2:0]]));
        chk(16'(lso), 16'(mb[7]));
        chk(16'(lls), 16'(mb[6]));
        chk(16'(lto), 16'(mb[5]));
        chk(16'(lm), 16'(mb[4:3]));
        chk(16'(cm), 16'(mb[1:0]));
        chk(16'(sw), 16'(mb[2] && mb[1:0] != 0));
        chk(16'(ws), 16'h0000);
    endtask

    task automatic wr(input int ad, input int d);
        host.acc(1'b1, 7'(ad), 16'(d), q, v);
        if (ad == 2) mh = d & `HWC_WMASK;
        if (ad == 3) mw = d & `WDC_WMASK;
        if (ad == 4) mb = d & `BUSC_WMASK;
        cmp_all;
    endtask

    task automatic rd(input int ad);
        host.acc(1'b0, 7'(ad), 16'h0000, q, v);
        chk(16'(v), 16'h0001);
        chk(q, 16'(ad == 2 ? mh : ad == 3 ? mw : ad == 4 ? mb : 0));
    endtask

    task automatic pulse(input int e);
        @(negedge i_clk);
        ev[e] = 1'b1;
        @(negedge i_clk);
        ev = 6'h00;
        chk(16'(ws), 16'(e == 5 && mw[4]));
        case (e)
            0: begin
                mh &= 32'h0200;
                mw = 32'h0014;
                mb = 32'h0000;
            end
            1: begin
                mh &= 32'h1240;
                mw = 32'h0014 | mw & 32'h0010;
                mb &= 32'h00d4;
            end
            2: mh &= ~32'h0004;
            3: if (!sys_err && mb[1]) mb = mb & ~32'h0003 | 32'h0001;
            4: mb = mb & 32'h00e0 | 32'h0009;
            default: ;
        endcase
        cmp_all;
    endtask

    // ------
    // Stimulus
    // ------
    initial begin
        repeat (10) @(negedge i_clk);
        srst = 1'b0;
        mh = 0;
        mw = 'h14;
        mb = 0;
        cmp_all;
        for (k = 0; k < 60; k++) begin
            a = 2 + {$random(seed)} % 4;
            fail = 1'($random(seed));
            sys_err = 1'($random(seed));
            wr(a, $random(seed));
            rd(a);
            pulse({$random(seed)} % 6);
        end
        fail = 1'b0;
        wr(2, 'h0020);
        fail = 1'b1;
        wr(2, 0);
        fail = 1'b0;
        cmp_all;
        wr(2, 'h1264);
        pulse(1);
        sys_err = 1'b0;
        wr(4, 'h0003);
        pulse(3);
        wr(3, 'h0010);
        pulse(5);
        wr(3, 0);
        pulse(5);
        ce = 1'b0;
        host.acc(1'b1, 7'h03, 16'h8025, q, v);
        ce = 1'b1;
        cmp_all;
        srst = 1'b1;
        @(negedge i_clk);
        srst = 1'b0;
        mh = 0;
        mw = 'h14;
        mb = 0;
        cmp_all;
        give_verdict;
    end

    initial begin
        #100000;
        n_errors++;
        give_verdict;
    end
endmodule // watchdog_bus_mode_control_regs_bench
